// File: tssd_pkg.sv
// package of constants and types for the trigger sequencer step decoder
// Contract
// - control 0010 disables, 0110 enables step delay
// - control 1000/1001 run timer, wait for limit
// - control 1011 waits software trigger rising edge
// - control 1100-1110 copy counter/literal into channel select
// - control 1111 fires all broadcast-enabled triggers
// - add 0000-0101 adds adjust to limit registers
// - copy 1000-1101 loads hold into limit registers
// - reserved commands or options act as nop
// - wait 0000-0100 select pwm event inputs
// - wait 0111-1111 select compare, capture, comparator, converter, irq
// - irq 0000-0011 raise interrupts; rest reserved
package tssd_pkg;
	localparam int DW = 16;
	localparam logic [3:0] CMD_CTRL = 4'h0;
	localparam logic [3:0] CMD_ADD = 4'h1;
	localparam logic [3:0] CMD_COPY = 4'h2;
	localparam logic [3:0] CMD_WHI = 4'h3;
	localparam logic [3:0] CMD_WLO = 4'h4;
	localparam logic [3:0] CMD_IRQ = 4'h5;
	localparam logic [3:0] CMD_TRIG = 4'h6;
	localparam logic [3:0] CMD_TRIG2 = 4'h7;
	localparam logic [3:0] OPT_SD_OFF = 4'h2;
	localparam logic [3:0] OPT_SD_ON = 4'h6;
	localparam logic [3:0] OPT_T0 = 4'h8;
	localparam logic [3:0] OPT_T1 = 4'h9;
	localparam logic [3:0] OPT_SWT = 4'hb;
	localparam logic [3:0] OPT_CH_C0 = 4'hc;
	localparam logic [3:0] OPT_CH_C1 = 4'hd;
	localparam logic [3:0] OPT_CH_L0 = 4'he;
	localparam logic [3:0] OPT_BCAST = 4'hf;
	localparam logic [3:0] OPT_ADD_LAST = 4'h5;
	localparam logic [3:0] OPT_COPY_FIRST = 4'h8;
	localparam logic [3:0] OPT_COPY_LAST = 4'hd;
	localparam logic [3:0] OPT_IRQ_LAST = 4'h3;
	localparam logic [3:0] OPT_WAIT_RSV0 = 4'h5;
	localparam logic [3:0] OPT_WAIT_RSV1 = 4'h6;
	// limit slot indices
	localparam logic [2:0] SLOT_C0 = 3'h0;
	localparam logic [2:0] SLOT_C1 = 3'h1;
	localparam logic [2:0] SLOT_T0 = 3'h2;
	localparam logic [2:0] SLOT_T1 = 3'h3;
	localparam logic [2:0] SLOT_SD = 3'h4;
	localparam logic [2:0] SLOT_L0 = 3'h5;
	localparam int NSLOT = 6;
	// wishbone register byte addresses
	localparam logic [7:0] A_STEP = 8'h00;
	localparam logic [7:0] A_ADJ = 8'h04;
	localparam logic [7:0] A_HOLD = 8'h08;
	localparam logic [7:0] A_C0 = 8'h0c;
	localparam logic [7:0] A_C1 = 8'h10;
	localparam logic [7:0] A_BTE = 8'h14;
	localparam logic [7:0] A_SWT = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1c;
	localparam logic [7:0] A_IST = 8'h20;
	localparam logic [7:0] A_IMASK = 8'h24;
	localparam logic [7:0] A_CHSEL = 8'h28;
	localparam logic [7:0] A_LIM0 = 8'h40;
	localparam int ST_BUSY = 0;
	localparam int ST_SDEN = 1;
	localparam int IRQ_W = 5;
	localparam int IRQ_DONE = 4;
	typedef enum logic [3:0] {
		TSSD_IDLE = 4'b0001,
		TSSD_TIMER = 4'b0010,
		TSSD_SWT = 4'b0100,
		TSSD_WAIT = 4'b1000
	} tssd_state_t;
endpackage

// File: tssd_top.sv
// step option decoder and executor with wishbone register access
`timescale 1ns/100ps
module tssd_top (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// peripheral event inputs, asynchronous
	input wire logic [15:0] event_in_i,
	// results
	output logic [tssd_pkg::DW-1:0] chan_sel_o,
	output logic [31:0] trig_out_o,
	output logic [3:0] seq_irq_o,
	output logic irq_o
);
	import tssd_pkg::*;

	logic [15:0] ev_meta;
	logic [15:0] ev_sync;
	logic [DW-1:0] adj_reg;
	logic [DW-1:0] hold_reg;
	logic [DW-1:0] cnt0;
	logic [DW-1:0] cnt1;
	logic [31:0] bte_reg;
	logic swt_bit;
	logic swt_prev;
	logic [DW-1:0] lim [NSLOT];
	logic [DW-1:0] tmr;
	logic sd_en;
	logic [IRQ_W-1:0] ist;
	logic [IRQ_W-1:0] imask;
	tssd_state_t state;
	logic [3:0] wopt;
	logic wlvl;
	logic step_go;
	logic [7:0] step_word;
	logic done_pulse;
	logic wb_hit;
	logic wr;
	logic rd;

	function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [DW-1:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction

	wire logic [3:0] cmd = step_word[7:4];
	wire logic [3:0] opt = step_word[3:0];
	wire logic [4:0] topt = step_word[4:0];
	assign wb_hit = cyc_i && stb_i && !ack_o;
	assign wr = wb_hit && we_i;
	assign rd = wb_hit && !we_i;

	// bus writes to the step register launch a step only while idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_go <= 1'b0;
			step_word <= 8'h00;
		end else begin
			step_go <= wr && adr_i == A_STEP && sel_i[0] && state == TSSD_IDLE;
			if (wr && adr_i == A_STEP && sel_i[0] && state == TSSD_IDLE) step_word <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_meta <= 16'h0000;
			ev_sync <= 16'h0000;
		end else begin
			ev_meta <= event_in_i;
			ev_sync <= ev_meta;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adj_reg <= '0;
			hold_reg <= '0;
			cnt0 <= '0;
			cnt1 <= '0;
			bte_reg <= 32'h0000_0000;
			swt_bit <= 1'b0;
			imask <= '0;
		end else if (wr) begin
			case (adr_i)
				A_ADJ: adj_reg <= wmerge(adj_reg, dat_i, sel_i);
				A_HOLD: hold_reg <= wmerge(hold_reg, dat_i, sel_i);
				A_C0: cnt0 <= wmerge(cnt0, dat_i, sel_i);
				A_C1: cnt1 <= wmerge(cnt1, dat_i, sel_i);
				A_BTE: bte_reg <= dat_i;
				A_SWT: if (sel_i[0]) swt_bit <= dat_i[0];
				A_IMASK: if (sel_i[0]) imask <= dat_i[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// limit registers: step arithmetic wins over a bus write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NSLOT; i++) lim[i] <= '0;
		end else if (step_go && cmd == CMD_ADD && opt <= OPT_ADD_LAST) begin
			lim[opt[2:0]] <= lim[opt[2:0]] + adj_reg;
		end else if (step_go && cmd == CMD_COPY && opt >= OPT_COPY_FIRST && opt <= OPT_COPY_LAST) begin
			lim[3'(opt - OPT_COPY_FIRST)] <= hold_reg;
		end else if (wr) begin
			for (int i = 0; i < NSLOT; i++)
				if (adr_i == A_LIM0 + 8'(4 * i)) lim[i] <= wmerge(lim[i], dat_i, sel_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) sd_en <= 1'b0;
		else if (step_go && cmd == CMD_CTRL && opt == OPT_SD_OFF) sd_en <= 1'b0;
		else if (step_go && cmd == CMD_CTRL && opt == OPT_SD_ON) sd_en <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) chan_sel_o <= '0;
		else if (step_go && cmd == CMD_CTRL) begin
			case (opt)
				OPT_CH_C0: chan_sel_o <= cnt0;
				OPT_CH_C1: chan_sel_o <= cnt1;
				OPT_CH_L0: chan_sel_o <= lim[SLOT_L0];
				default: ;
			endcase
		end
	end

	// trigger and sequencer interrupt outputs are single-cycle pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_out_o <= 32'h0000_0000;
			seq_irq_o <= 4'h0;
		end else begin
			trig_out_o <= 32'h0000_0000;
			seq_irq_o <= 4'h0;
			if (step_go && cmd == CMD_CTRL && opt == OPT_BCAST) trig_out_o <= bte_reg;
			if (step_go && (cmd == CMD_TRIG || cmd == CMD_TRIG2)) trig_out_o <= 32'h1 << topt;
			if (step_go && cmd == CMD_IRQ && opt <= OPT_IRQ_LAST) seq_irq_o <= 4'h1 << opt[1:0];
		end
	end

	// wait sequencing; reserved wait options fall straight through as nop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= TSSD_IDLE;
			tmr <= '0;
			wopt <= 4'h0;
			wlvl <= 1'b0;
			swt_prev <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= 1'b0;
			swt_prev <= swt_bit;
			case (state)
				TSSD_IDLE: begin
					tmr <= '0;
					if (step_go) begin
						done_pulse <= 1'b1;
						if (cmd == CMD_CTRL && (opt == OPT_T0 || opt == OPT_T1)) begin
							state <= TSSD_TIMER;
							wopt <= opt;
							done_pulse <= 1'b0;
						end else if (cmd == CMD_CTRL && opt == OPT_SWT) begin
							state <= TSSD_SWT;
							done_pulse <= 1'b0;
						end else if ((cmd == CMD_WHI || cmd == CMD_WLO) && opt != OPT_WAIT_RSV0 && opt != OPT_WAIT_RSV1) begin
							state <= TSSD_WAIT;
							wopt <= opt;
							wlvl <= cmd == CMD_WHI;
							done_pulse <= 1'b0;
						end
					end
				end
				TSSD_TIMER: begin
					tmr <= tmr + 1'b1;
					if (tmr == lim[wopt == OPT_T0 ? SLOT_T0 : SLOT_T1]) begin
						state <= TSSD_IDLE;
						done_pulse <= 1'b1;
					end
				end
				TSSD_SWT: if (swt_bit && !swt_prev) begin
					state <= TSSD_IDLE;
					done_pulse <= 1'b1;
				end
				TSSD_WAIT: if (ev_sync[wopt] == wlvl) begin
					state <= TSSD_IDLE;
					done_pulse <= 1'b1;
				end
				default: state <= TSSD_IDLE;
			endcase
		end
	end

	// sticky status: set wins over read-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) ist <= '0;
		else ist <= ((rd && adr_i == A_IST) ? '0 : ist) | {done_pulse, seq_irq_o};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) irq_o <= 1'b0;
		else irq_o <= |(((rd && adr_i == A_IST) ? '0 : ist) & imask) || |({done_pulse, seq_irq_o} & imask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= wb_hit;
			dat_o <= 32'h0000_0000;
			if (rd) begin
				case (adr_i)
					A_STEP: dat_o <= {24'h0, step_word};
					A_ADJ: dat_o <= {16'h0, adj_reg};
					A_HOLD: dat_o <= {16'h0, hold_reg};
					A_C0: dat_o <= {16'h0, cnt0};
					A_C1: dat_o <= {16'h0, cnt1};
					A_BTE: dat_o <= bte_reg;
					A_SWT: dat_o <= {31'h0, swt_bit};
					A_STAT: dat_o <= {30'h0, sd_en, state != TSSD_IDLE};
					A_IST: dat_o <= {27'h0, ist};
					A_IMASK: dat_o <= {27'h0, imask};
					A_CHSEL: dat_o <= {16'h0, chan_sel_o};
					default: begin
						for (int i = 0; i < NSLOT; i++)
							if (adr_i == A_LIM0 + 8'(4 * i)) dat_o <= {16'h0, lim[i]};
					end
				endcase
			end
		end
	end

	sequence s_bcast_step;
		step_go && cmd == CMD_CTRL && opt == OPT_BCAST;
	endsequence

	sequence s_timer_step;
		step_go && cmd == CMD_CTRL && (opt == OPT_T0 || opt == OPT_T1);
	endsequence

	// reserved wait options never enter the wait state
	sequence s_wait_step;
		step_go && (cmd == CMD_WHI || cmd == CMD_WLO) && opt != OPT_WAIT_RSV0 && opt != OPT_WAIT_RSV1;
	endsequence

	chk_sd_off: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_CTRL && opt == OPT_SD_OFF |=> !sd_en) else $error("step delay not disabled");
	chk_sd_on: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_CTRL && opt == OPT_SD_ON |=> sd_en) else $error("step delay not enabled");
	chk_timer_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_CTRL && opt == OPT_T0 |=> state == TSSD_TIMER) else $error("timer wait not entered");
	chk_swt_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		state == TSSD_SWT && !(swt_bit && !swt_prev) |=> state == TSSD_SWT) else $error("left swt wait early");
	chk_chan_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_CTRL && opt == OPT_CH_C0 |=> chan_sel_o == $past(cnt0)) else $error("channel copy wrong");
	chk_bcast_trig: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bcast_step |=> trig_out_o == $past(bte_reg)) else $error("broadcast mismatch");
	chk_add_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_ADD && opt == 4'h0 |=> lim[0] == $past(lim[0]) + $past(adj_reg)) else $error("add wrong");
	chk_copy_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_COPY && opt == OPT_COPY_FIRST |=> lim[0] == $past(hold_reg)) else $error("copy wrong");
	chk_nop_done: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_ADD && opt > OPT_ADD_LAST |=> done_pulse && $stable(lim[0])) else $error("reserved not nop");
	chk_irq_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_IRQ && opt > OPT_IRQ_LAST |=> seq_irq_o == 4'h0) else $error("reserved irq fired");
	chk_trig_one: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_TRIG |=> $onehot(trig_out_o)) else $error("trigger not one-hot");
	chk_timer_run: assert property (@(posedge clk_i) disable iff (rst_i)
		s_timer_step |=> state == TSSD_TIMER && tmr == '0) else $error("timer wait not started from zero");
	chk_timer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		state == TSSD_TIMER && tmr != lim[wopt == OPT_T0 ? SLOT_T0 : SLOT_T1]
		|=> state == TSSD_TIMER && tmr == $past(tmr) + 1'b1) else $error("timer wait ended before limit");
	chk_timer_end: assert property (@(posedge clk_i) disable iff (rst_i)
		state == TSSD_TIMER && tmr == lim[wopt == OPT_T0 ? SLOT_T0 : SLOT_T1]
		|=> state == TSSD_IDLE && done_pulse) else $error("timer wait did not end at limit");
	chk_wait_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wait_step |=> state == TSSD_WAIT) else $error("event wait not entered");
	chk_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		state == TSSD_WAIT && ev_sync[wopt] != wlvl |=> state == TSSD_WAIT) else $error("event wait left early");
	chk_wait_end: assert property (@(posedge clk_i) disable iff (rst_i)
		state == TSSD_WAIT && ev_sync[wopt] == wlvl |=> state == TSSD_IDLE && done_pulse) else $error("event wait stuck");
	chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_IRQ && opt <= OPT_IRQ_LAST |=> seq_irq_o == 4'h1 << $past(opt[1:0]))
		else $error("sequencer interrupt wrong");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(ist & $past(imask))) else $error("interrupt level wrong");
	chk_copy_lit: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_COPY && opt == OPT_COPY_LAST |=> lim[SLOT_L0] == $past(hold_reg))
		else $error("literal copy wrong");
	chk_chan_lit: assert property (@(posedge clk_i) disable iff (rst_i)
		step_go && cmd == CMD_CTRL && opt == OPT_CH_L0 |=> chan_sel_o == $past(lim[SLOT_L0]))
		else $error("literal channel copy wrong");
endmodule

// File: tssd_periph_model.sv
// peripheral event sources seen by the step decoder
`timescale 1ns/100ps
module tssd_periph_model (
	// control
	input wire logic clk_i,
	input wire logic [3:0] src_i,
	input wire logic lvl_i,
	input wire logic go_i,
	// events
	output logic [15:0] event_o
);
	// idle lines sit at the opposite level, so a wrong select never ends a wait
	always_ff @(posedge clk_i) begin
		event_o <= go_i ? ({16{~lvl_i}} ^ (16'h1 << src_i)) : {16{~lvl_i}};
	end
endmodule

// File: test_trigger_sequencer_step_decode.sv
// self-checking bench for the step decoder
`timescale 1ns/100ps
module test_trigger_sequencer_step_decode;
	import tssd_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o, trig_out_o, rd;
	logic ack_o, irq_o, lvl = 1, go = 0;
	logic [3:0] src = 4'h0, seq_irq_o;
	logic [15:0] event_in_i, chan_sel_o;
	int err_count = 0, checks = 0;
	always #5 clk_i = ~clk_i;
	tssd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .event_in_i(event_in_i),
		.chan_sel_o(chan_sel_o), .trig_out_o(trig_out_o), .seq_irq_o(seq_irq_o), .irq_o(irq_o));
	tssd_periph_model peri (.clk_i(clk_i), .src_i(src), .lvl_i(lvl), .go_i(go), .event_o(event_in_i));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; read data is taken at the ack edge only
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		sel_i <= 4'hf;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		if (n >= 50) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic step(input logic [7:0] s);
		wb(1, A_STEP, {24'h0, s});
		#1;
	endtask
	task automatic wait_idle;
		int n = 0;
		do begin
			wb(0, A_STAT, 0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 100);
		if (rd[ST_BUSY] !== 1'b0) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic t_limits;
		for (int i = 0; i < NSLOT; i++) begin
			wb(1, A_HOLD, 32'h0100 + i);
			step({CMD_COPY, 4'h8 + 4'(i)});
			wb(0, A_LIM0 + 8'(4 * i), 0);
			cmp(rd, 32'h0100 + i);
			wb(1, A_ADJ, 32'h0011);
			step({CMD_ADD, 4'(i)});
			wb(0, A_LIM0 + 8'(4 * i), 0);
			cmp(rd, 32'h0111 + i);
		end
		// an add with a copy option and a copy with an add option touch no limit
		step({CMD_ADD, 4'h8});
		step({CMD_COPY, 4'h0});
		wb(0, A_LIM0, 0);
		cmp(rd, 32'h0111);
		$display("test limits done");
	endtask
	task automatic t_chan;
		wb(1, A_C0, 32'h0007);
		wb(1, A_C1, 32'h0019);
		step({CMD_CTRL, OPT_CH_C0});
		cmp(chan_sel_o, 16'h0007);
		step({CMD_CTRL, OPT_CH_C1});
		cmp(chan_sel_o, 16'h0019);
		step({CMD_CTRL, OPT_CH_L0});
		cmp(chan_sel_o, 16'h0116);
		// reserved control options and an undefined command leave everything alone
		step(8'h00);
		step(8'h0a);
		step(8'h8c);
		cmp(trig_out_o, 0);
		cmp(chan_sel_o, 16'h0116);
		wb(1, 8'h3c, 32'hffff);
		wb(0, 8'h3c, 0);
		cmp(rd, 0);
		$display("test channel done");
	endtask
	task automatic t_trig;
		for (int n = 0; n < 32; n++) begin
			step({3'h3, 5'(n)});
			cmp(trig_out_o, 32'h1 << n);
		end
		wb(1, A_BTE, 32'ha5c30f18);
		step({CMD_CTRL, OPT_BCAST});
		cmp(trig_out_o, 32'ha5c30f18);
		@(posedge clk_i);
		#1;
		cmp(trig_out_o, 0);
		$display("test triggers done");
	endtask
	task automatic t_irq;
		wb(0, A_IST, 0);
		wb(1, A_IMASK, 32'h0001);
		for (int n = 0; n < 5; n++) begin
			step({CMD_IRQ, 4'(n)});
			cmp(seq_irq_o, n < 4 ? 4'h1 << n : 4'h0);
		end
		cmp(irq_o, 1);
		wb(0, A_IST, 0);
		cmp(rd[4:0], 5'h1f);
		step({CMD_IRQ, 4'h1});
		repeat (3) @(posedge clk_i);
		#1;
		cmp(irq_o, 0);
		$display("test interrupts done");
	endtask
	task automatic t_ctl;
		step({CMD_CTRL, OPT_SD_ON});
		wb(0, A_STAT, 0);
		cmp(rd[ST_SDEN], 1);
		step({CMD_CTRL, OPT_SD_OFF});
		wb(0, A_STAT, 0);
		cmp(rd[ST_SDEN], 0);
		wb(1, A_HOLD, 32'h0006);
		step({CMD_COPY, 4'ha});
		step({CMD_COPY, 4'hb});
		for (int t = 0; t < 2; t++) begin
			step({CMD_CTRL, 4'h8 + 4'(t)});
			wb(0, A_STAT, 0);
			cmp(rd[ST_BUSY], 1);
			wait_idle();
		end
		// a bit already high on entry is not an edge
		wb(1, A_SWT, 1);
		step({CMD_CTRL, OPT_SWT});
		wb(1, A_SWT, 0);
		wb(0, A_STAT, 0);
		cmp(rd[ST_BUSY], 1);
		wb(1, A_SWT, 1);
		wait_idle();
		$display("test control done");
	endtask
	task automatic t_wait(input logic [3:0] cmd, input logic level);
		for (int o = 0; o < 16; o++) begin
			src <= 4'(o);
			lvl <= level;
			go <= 0;
			// let the event synchroniser settle on the unsatisfied level
			repeat (4) @(posedge clk_i);
			step({cmd, 4'(o)});
			wb(0, A_STAT, 0);
			cmp(rd[ST_BUSY], (o != 5 && o != 6));
			go <= 1;
			wait_idle();
		end
		$display("test wait %h done", cmd);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		#1;
		cmp(trig_out_o, 0);
		cmp({ack_o, seq_irq_o, irq_o, chan_sel_o}, 0);
		t_limits();
		t_chan();
		t_trig();
		t_irq();
		t_ctl();
		t_wait(CMD_WHI, 1);
		t_wait(CMD_WLO, 0);
		give_verdict();
	end
endmodule
